// ---- logic/safety_feedback_pkg.sv ----
// package: shared constants for the safety feedback monitor and its controller
// assumes a 100 MHz clock on both ends
package safety_feedback_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  // times as printed, in microseconds
  localparam int unsigned GLITCH_US = 500;
  localparam int unsigned FEEDBACK_MAX_US = 20_000;
  localparam int unsigned PAIR_TIMEOUT_US = 10_000_000;
  // cycle counts derived from the rate; each is a plain product of microseconds and cycles per microsecond
  localparam int unsigned GLITCH_CYC = (GLITCH_US * (CLK_HZ / 1_000_000));
  localparam int unsigned FEEDBACK_MAX_CYC = (FEEDBACK_MAX_US * (CLK_HZ / 1_000_000));
  localparam longint unsigned PAIR_TIMEOUT_CYC = 64'(PAIR_TIMEOUT_US) * 64'(CLK_HZ / 1_000_000);
  // feedback is settled well inside its bound; this is the controller's wait before judging it
  localparam int unsigned CHECK_WAIT_CYC = 4;
  localparam logic [3:0] RESET_FEEDBACK = 4'h0;
endpackage : safety_feedback_pkg

// ---- logic/safety_link_if.sv ----
// interface: the two safety inputs and the feedback line between controller and drive
// assumes both ends share one clock; pins are plain one-way levels
`timescale 1ns/1ps
`default_nettype none
interface safety_link_if;
  logic safety_input_a;
  logic safety_input_b;
  logic monitor_feedback_output;
  modport drive (input safety_input_a, input safety_input_b, output monitor_feedback_output);
  modport controller (output safety_input_a, output safety_input_b, input monitor_feedback_output);
endinterface : safety_link_if
`default_nettype wire

// ---- logic/safety_feedback_monitor.sv ----
// drive end: filters the two shut-off inputs, drives feedback, baseblock and alarm
// assumes the inputs arrive asynchronously from the connector; high means asserted (closed)
//
// Function
// - feedback only when both inputs deasserted
// - feedback follows input changes within 20 ms
// - controller checks all four combinations at power-up; this controller checks only feedback with both inputs off, at each guard close
// - controller drops both inputs when guard opens
// - controller resets only with feedback asserted
// - no feedback at guard close: withhold reset
// - open connector means hard baseblock, no current
// - status view shows each input state
// - either input deasserted forces hard baseblock
// - ignore off pulses of 0.5 ms or less
// - unmatched single change for 10 s raises alarm
`timescale 1ns/1ps
`default_nettype none
module safety_feedback_monitor
  import safety_feedback_pkg::*;
#(
  parameter int unsigned GLITCH_CYCLES = GLITCH_CYC,
  parameter longint unsigned PAIR_TIMEOUT_CYCLES = PAIR_TIMEOUT_CYC
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  safety_link_if.drive link,
  input wire logic alarm_clear_i,
  output logic hard_baseblock_o,
  output logic motor_current_enable_o,
  output logic input_timing_alarm_o,
  output logic [1:0] safety_input_status_view_o
);
  logic [2:0] sync_a_q;
  logic [2:0] sync_b_q;
  logic [1:0] raw;
  logic [1:0] filt_q;
  logic sampled_q;
  logic feedback_q;
  logic alarm_q;
  logic [31:0] off_cnt_q [2];
  logic [63:0] pair_cnt_q;

  // three stages; a change counts once stages two and three agree
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync_a_q <= 3'h0;
      sync_b_q <= 3'h0;
    end else begin
      sync_a_q <= {sync_a_q[1:0], link.safety_input_a};
      sync_b_q <= {sync_b_q[1:0], link.safety_input_b};
    end
  end
  assign raw[0] = (sync_a_q[1] == sync_a_q[2]) ? sync_a_q[2] : filt_q[0];
  assign raw[1] = (sync_b_q[1] == sync_b_q[2]) ? sync_b_q[2] : filt_q[1];

  // off must last beyond the glitch time before it counts; reset starts deasserted (open connector)
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_filter
      always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          off_cnt_q[ch] <= 32'h0000_0000;
          filt_q[ch] <= 1'b0;
        end else if (raw[ch]) begin
          off_cnt_q[ch] <= 32'h0000_0000;
          filt_q[ch] <= 1'b1;
        end else if (filt_q[ch]) begin
          if (off_cnt_q[ch] >= GLITCH_CYCLES) begin
            filt_q[ch] <= 1'b0;
          end else begin
            off_cnt_q[ch] <= off_cnt_q[ch] + 32'h0000_0001;
          end
        end
      end
    end
  endgenerate

  // one clock of settling after reset before the feedback may assert
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sampled_q <= 1'b0;
    end else begin
      sampled_q <= 1'b1;
    end
  end

  // latency is a few cycles plus the glitch time, far inside the 20 ms bound
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      feedback_q <= 1'b0;
    end else begin
      feedback_q <= sampled_q && !filt_q[0] && !filt_q[1];
    end
  end
  assign link.monitor_feedback_output = feedback_q;

  // an open connector reads as both inputs off, so it lands here too
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hard_baseblock_o <= 1'b1;
      motor_current_enable_o <= 1'b0;
    end else begin
      hard_baseblock_o <= !(filt_q[0] && filt_q[1]);
      motor_current_enable_o <= filt_q[0] && filt_q[1];
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      safety_input_status_view_o <= 2'h0;
    end else begin
      safety_input_status_view_o <= filt_q;
    end
  end

  // mismatch timer; alarm is not safety-related, it only reports wiring faults
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pair_cnt_q <= 64'h0000_0000_0000_0000;
    end else if (filt_q[0] != filt_q[1]) begin
      if (pair_cnt_q < PAIR_TIMEOUT_CYCLES) begin
        pair_cnt_q <= pair_cnt_q + 64'h0000_0000_0000_0001;
      end
    end else begin
      pair_cnt_q <= 64'h0000_0000_0000_0000;
    end
  end

  // set wins over clear
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      alarm_q <= 1'b0;
    end else if ((filt_q[0] != filt_q[1]) && (pair_cnt_q >= PAIR_TIMEOUT_CYCLES)) begin
      alarm_q <= 1'b1;
    end else if (alarm_clear_i) begin
      alarm_q <= 1'b0;
    end
  end
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      input_timing_alarm_o <= 1'b0;
    end else begin
      input_timing_alarm_o <= alarm_q;
    end
  end
endmodule : safety_feedback_monitor
`default_nettype wire

// ---- logic/safety_controller.sv ----
// controller end: drives both shut-off inputs from a guard switch and checks the feedback
// assumes guard_closed_i is already synchronous to clock_i
`timescale 1ns/1ps
`default_nettype none
module safety_controller
  import safety_feedback_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_n_i,
  safety_link_if.controller link,
  input wire logic guard_closed_i,
  output logic running_o,
  output logic failure_o
);
  typedef enum logic [1:0] {
    ST_OPEN = 2'b00,
    ST_WAIT = 2'b01,
    ST_RUN = 2'b10,
    ST_FAIL = 2'b11
  } ctl_state_t;
  ctl_state_t state_q;
  logic [7:0] wait_q;
  logic [2:0] fb_sync_q;
  logic fb;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fb_sync_q <= 3'h0;
    end else begin
      fb_sync_q <= {fb_sync_q[1:0], link.monitor_feedback_output};
    end
  end
  assign fb = fb_sync_q[2] && fb_sync_q[1];

  // starts with inputs off so its only check, at guard close, sees the off/off/on combination
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= ST_OPEN;
      wait_q <= 8'h00;
    end else begin
      case (state_q)
        ST_OPEN: begin
          wait_q <= 8'h00;
          if (guard_closed_i) begin
            state_q <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          wait_q <= wait_q + 8'h01;
          if (!guard_closed_i) begin
            state_q <= ST_OPEN;
          end else if (wait_q >= 8'(CHECK_WAIT_CYC)) begin
            state_q <= fb ? ST_RUN : ST_FAIL;
          end
        end
        ST_RUN: begin
          if (!guard_closed_i) begin
            state_q <= ST_OPEN;
          end
        end
        ST_FAIL: begin
          state_q <= ST_FAIL;
        end
        default: begin
          state_q <= ST_OPEN;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      link.safety_input_a <= 1'b0;
      link.safety_input_b <= 1'b0;
      running_o <= 1'b0;
      failure_o <= 1'b0;
    end else begin
      link.safety_input_a <= (state_q == ST_RUN) && guard_closed_i;
      link.safety_input_b <= (state_q == ST_RUN) && guard_closed_i;
      running_o <= state_q == ST_RUN;
      failure_o <= state_q == ST_FAIL;
    end
  end
endmodule : safety_controller
`default_nettype wire

// ---- test/safety_link_asserts.sv ----
// checker: timing on the link between controller and drive end
// assumes one clock domain and sees the link signals only
`timescale 1ns/1ps
`default_nettype none
module safety_link_asserts (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic safety_input_a,
  input wire logic safety_input_b,
  input wire logic monitor_feedback_output
);
  logic any_on;
  assign any_on = safety_input_a | safety_input_b;
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);
  // bounds assume the shortened filter count of the bench
  a_fb_off_on: assert property (any_on [*8] |-> !monitor_feedback_output)
    else $error("feedback with input on");
  a_fb_rise_cause: assert property ($rose(monitor_feedback_output) |-> !$past(any_on))
    else $error("feedback rose early");
  a_fb_on_off: assert property ((!any_on) [*8] ##1 (!any_on) [*8] ##1 (!any_on) [*8] |-> monitor_feedback_output)
    else $error("feedback missing");
  a_fb_drop_time: assert property ($rose(any_on) |-> ##[0:8] !monitor_feedback_output)
    else $error("feedback slow to drop");
  a_fb_reset_off: assert property ($rose(rst_n_i) |-> !monitor_feedback_output)
    else $error("feedback at reset");
  a_pair_together: assert property (safety_input_a == safety_input_b)
    else $error("inputs split");
  a_rearm_fb: assert property ($rose(safety_input_a) |-> $past(monitor_feedback_output))
    else $error("rearm without feedback");
  a_rearm_after_off: assert property ($rose(safety_input_a) |-> !$past(any_on, 4))
    else $error("rearm too early");
endmodule : safety_link_asserts
`default_nettype wire

// ---- test/safety_feedback_monitor_tb.sv ----
// testbench: controller and drive end joined, plus a drive end fed by the bench
// assumes shortened filter and pairing counts
`timescale 1ns/1ps
`default_nettype none
module safety_feedback_monitor_tb;
  localparam longint unsigned PT = 100;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic guard = 1'b0;
  logic clr = 1'b0;
  logic running, failure, bb0, cur0, bb1, cur1, alarm;
  logic [1:0] view0, view1;
  int n_fail = 0;
  int num_checks = 0;
  safety_link_if link0 ();
  safety_link_if link1 ();
  always #5 clock_i = ~clock_i;
  safety_controller safety_controller_i (.clock_i(clock_i), .rst_n_i(rst_n_i), .link(link0),
    .guard_closed_i(guard), .running_o(running), .failure_o(failure));
  safety_feedback_monitor #(.GLITCH_CYCLES(8), .PAIR_TIMEOUT_CYCLES(PT)) safety_feedback_monitor_i (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .link(link0), .alarm_clear_i(1'b0), .hard_baseblock_o(bb0),
    .motor_current_enable_o(cur0), .input_timing_alarm_o(), .safety_input_status_view_o(view0));
  // second drive end lets the bench break the pairing the controller always keeps
  safety_feedback_monitor #(.GLITCH_CYCLES(8), .PAIR_TIMEOUT_CYCLES(PT)) safety_feedback_monitor_i2 (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .link(link1), .alarm_clear_i(clr), .hard_baseblock_o(bb1),
    .motor_current_enable_o(cur1), .input_timing_alarm_o(alarm), .safety_input_status_view_o(view1));
  safety_link_asserts safety_link_asserts_i (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .safety_input_a(link0.safety_input_a), .safety_input_b(link0.safety_input_b),
    .monitor_feedback_output(link0.monitor_feedback_output));
  task automatic step(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask : step
  task automatic chk(input string what, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask : chk
  task automatic print_verdict();
    if (n_fail == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict
  task automatic t_guard(input logic g);
    guard = g;
    step(30);
    chk("fb", !g, link0.monitor_feedback_output);
    chk("bb", !g, bb0);
    chk("cur", g, cur0);
    chk("run", g, running);
    chk("view", g, &view0);
  endtask : t_guard
  task automatic t_combos();
    for (int i = 0; i < 4; i++) begin
      link1.safety_input_a = i[0];
      link1.safety_input_b = i[1];
      step(30);
      chk("fb1", i == 0, link1.monitor_feedback_output);
      chk("bb1", i != 3, bb1);
      chk("cur1", i == 3, cur1);
      chk("view_a", i[0], view1[0]);
      chk("view_b", i[1], view1[1]);
    end
  endtask : t_combos
  task automatic t_glitch();
    link1.safety_input_a = 1'b0;
    step(4);
    link1.safety_input_a = 1'b1;
    repeat (20) begin
      step(1);
      chk("bb glitch", 1'b0, bb1);
    end
  endtask : t_glitch
  task automatic t_alarm();
    link1.safety_input_a = 1'b0;
    step(60);
    chk("alarm early", 1'b0, alarm);
    step(80);
    chk("alarm", 1'b1, alarm);
    link1.safety_input_a = 1'b1;
    step(10);
    clr = 1'b1;
    step(1);
    clr = 1'b0;
    step(5);
    chk("alarm clr", 1'b0, alarm);
  endtask : t_alarm
  task automatic t_stuck();
    guard = 1'b0;
    step(2);
    // reclosed before feedback can rise, as a stuck channel would look
    guard = 1'b1;
    step(30);
    chk("fail", 1'b1, failure);
    chk("run stuck", 1'b0, running);
    chk("bb stuck", 1'b1, bb0);
    chk("cur stuck", 1'b0, cur0);
    chk("fb stuck", 1'b1, link0.monitor_feedback_output);
  endtask : t_stuck
  initial begin
    link1.safety_input_a = 1'b0;
    link1.safety_input_b = 1'b0;
    step(10);
    rst_n_i = 1'b1;
    chk("fb rst", 1'b0, link1.monitor_feedback_output);
    t_guard(1'b0);
    t_guard(1'b1);
    t_guard(1'b0);
    t_guard(1'b1);
    t_combos();
    t_glitch();
    t_alarm();
    t_stuck();
    print_verdict();
  end
  initial begin
    #50000;
    n_fail++;
    print_verdict();
  end
endmodule : safety_feedback_monitor_tb
`default_nettype wire
